/* File: dsr_pkg.sv */
// Behaviour
// - Shift register contents go out serially
// - Output edge follows the selected output mode
// - Power-up picks falling edge, 16-cycle lag
// - Rising-edge mode lags input by 15.5 cycles
// - Serial output holds its level in shutdown
// - Logic output set by serial commands and by clear
// - Logic output holds its level in shutdown
// - Clear returns logic output low in the same cycle it leaves shutdown
// - Clear loads zero or mid-scale per select
// - Clear also leaves software shutdown
// - Power-up loads both registers per select
// - Code field is unsigned straight binary
// - Frame: 3 control, 12 code, zero sub-bit
// - Sample on rising clock, act on select rise
// - Code 111 chooses the output edge mode
// - Codes 100 and 110 drive logic output
package dsr_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS  = 12;
  localparam int CTRL_BITS  = 3;

  // Output edge lags, in half serial clock cycles.
  localparam int LAG_FALL_HALF = 32;
  localparam int LAG_RISE_HALF = 31;

  localparam logic [2:0] CTL_NOP       = 3'h0;
  localparam logic [2:0] CTL_LOAD_IN   = 3'h1;
  localparam logic [2:0] CTL_LOAD_BOTH = 3'h2;
  localparam logic [2:0] CTL_UPDATE    = 3'h3;
  localparam logic [2:0] CTL_UPO_LOW   = 3'h4;
  localparam logic [2:0] CTL_SHUTDOWN  = 3'h5;
  localparam logic [2:0] CTL_UPO_HIGH  = 3'h6;
  localparam logic [2:0] CTL_EDGE_MODE = 3'h7;

  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID  = 12'h800;

  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] INIT_WAIT = 2'h3;

  typedef struct packed {
    logic [2:0]  ctrl;
    logic [11:0] code;
    logic        sub_bit;
  } dsr_frame_s;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,
    ST_RUN   = 3'b010,
    ST_CLEAR = 3'b100
  } dsr_state_e;

endpackage

/* File: dsr_sync.sv */
`timescale 1ns/10ps
module dsr_sync
  import dsr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;

endmodule // dsr_sync

/* File: dsr_fifo.sv */
`timescale 1ns/10ps
module dsr_fifo
  import dsr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty     = (wr_reg == rd_reg);
  assign full      = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push) begin
      mem_next[wr_reg[AW-1:0]] = in_data;
      wr_next                  = wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = rd_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      mem_reg <= mem_next;
    end
  end

endmodule // dsr_fifo

/* File: dsr_top.sv */
`timescale 1ns/10ps
module dsr_top
  import dsr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        serial_clk,
  input  wire logic        chip_select_n,
  input  wire logic        serial_din,
  output logic             serial_dout,
  input  wire logic        clear_input_n,
  input  wire logic        reset_value_select,
  input  wire logic        shutdown_pin,
  input  wire logic        shutdown_lockout,
  input  wire logic        dac_ready,
  output logic [11:0]      input_code,
  output logic [11:0]      dac_code,
  output logic             dac_load,
  output logic             user_logic_output,
  output logic             shutdown,
  output logic             mode_rise,
  output logic             frame_drop
);

  // Link domain: serial clock.
  logic [15:0] sr_reg;
  logic [15:0] sr_next;
  logic        dout_rise_reg;
  logic        dout_rise_next;
  logic        dout_fall_reg;
  logic        dout_fall_next;
  logic [1:0]  link_ctl;
  logic        shutdown_reg;
  logic        mode_rise_reg;
  logic        dout_link;

  dsr_sync #(
    .W (2)
  ) u_sync_link (
    .clk   (serial_clk),
    .rst_n (rst_n),
    .d     ({shutdown_reg, mode_rise_reg}),
    .q     (link_ctl)
  );

  always_comb begin
    sr_next        = sr_reg;
    dout_rise_next = dout_rise_reg;
    if (!chip_select_n) begin
      sr_next = {sr_reg[14:0], serial_din};
    end
    if (!link_ctl[1] && !chip_select_n) begin
      dout_rise_next = sr_reg[14];
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg        <= '0;
      dout_rise_reg <= 1'b0;
    end else begin
      sr_reg        <= sr_next;
      dout_rise_reg <= dout_rise_next;
    end
  end

  always_comb begin
    dout_fall_next = dout_fall_reg;
    if (!link_ctl[1]) begin
      dout_fall_next = sr_reg[15];
    end
  end

  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_fall_reg <= 1'b0;
    end else begin
      dout_fall_reg <= dout_fall_next;
    end
  end

  // The edge choice is a mux of two flops, since one flop cannot clock on both edges.
  // edge select
  assign dout_link = link_ctl[0] ? dout_rise_reg : dout_fall_reg;

  // System domain.
  logic [4:0] pins_s;
  logic       cs_s;
  logic       clr_n_s;
  logic       sel_s;
  logic       pd_s;
  logic       lock_s;

  dsr_sync #(
    .W (5)
  ) u_sync_sys (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     ({~chip_select_n, ~clear_input_n, reset_value_select, shutdown_pin,
             shutdown_lockout}),
    .q     (pins_s)
  );

  // Inverted so that the synchroniser's reset value is the idle level: no false frame end.
  assign cs_s    = ~pins_s[4];
  assign clr_n_s = ~pins_s[3];
  assign sel_s   = pins_s[2];
  assign pd_s    = pins_s[1];
  assign lock_s  = pins_s[0];

  logic       cs_d_reg;
  logic       cs_d_next;
  logic       lock_d_reg;
  logic       lock_d_next;
  logic       frame_end;
  logic       lock_fall;

  always_comb begin
    cs_d_next   = cs_s;
    lock_d_next = lock_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_reg   <= 1'b1;
      lock_d_reg <= 1'b0;
    end else begin
      cs_d_reg   <= cs_d_next;
      lock_d_reg <= lock_d_next;
    end
  end

  assign frame_end = cs_s && !cs_d_reg;
  assign lock_fall = lock_d_reg && !lock_s;

  // The shift register is still while select is high, so it is read whole here.
  dsr_frame_s fifo_out;
  logic [15:0] fifo_out_w;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;

  dsr_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (frame_end),
    .in_ready  (fifo_in_ready),
    .in_data   (sr_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_w)
  );

  assign fifo_out = fifo_out_w;

  dsr_state_e  state_reg;
  dsr_state_e  state_next;
  logic [1:0]  init_cnt_reg;
  logic [1:0]  init_cnt_next;
  logic [11:0] input_code_reg;
  logic [11:0] input_code_next;
  logic [11:0] dac_code_reg;
  logic [11:0] dac_code_next;
  logic        dac_load_reg;
  logic        dac_load_next;
  logic        upo_reg;
  logic        upo_next;
  logic        shutdown_next;
  logic        mode_rise_next;
  logic        dout_hold_reg;
  logic        dout_hold_next;
  logic        frame_drop_reg;
  logic        frame_drop_next;
  logic [11:0] reset_code;

  assign reset_code = sel_s ? CODE_MID : CODE_ZERO;
  assign fifo_pop   = (state_reg == ST_RUN) && dac_ready && fifo_out_valid;

  always_comb begin
    state_next      = state_reg;
    init_cnt_next   = init_cnt_reg;
    input_code_next = input_code_reg;
    dac_code_next   = dac_code_reg;
    dac_load_next   = 1'b0;
    upo_next        = upo_reg;
    shutdown_next   = shutdown_reg;
    mode_rise_next  = mode_rise_reg;
    frame_drop_next = frame_drop_reg;
    dout_hold_next  = shutdown_reg ? dout_hold_reg : dout_link;
    case (state_reg)
      ST_INIT: begin
        // Waits out the select pin's synchroniser before loading.
        init_cnt_next = init_cnt_reg + 2'h1;
        if (init_cnt_reg == INIT_WAIT) begin
          input_code_next = reset_code;
          dac_code_next   = reset_code;
          dac_load_next   = 1'b1;
          state_next      = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!clr_n_s) begin
          state_next = ST_CLEAR;
        end else if (fifo_pop) begin
          case (fifo_out.ctrl)
            CTL_LOAD_IN: begin
              input_code_next = fifo_out.code;
            end
            CTL_LOAD_BOTH: begin
              input_code_next = fifo_out.code;
              dac_code_next   = fifo_out.code;
              dac_load_next   = 1'b1;
              shutdown_next   = 1'b0;
            end
            CTL_UPDATE: begin
              dac_code_next = input_code_reg;
              dac_load_next = 1'b1;
              shutdown_next = 1'b0;
            end
            CTL_SHUTDOWN: begin
              if (lock_s) begin
                shutdown_next = 1'b1;
              end
            end
            CTL_UPO_LOW: begin
              if (!shutdown_reg) begin
                upo_next = 1'b0;
              end
            end
            CTL_UPO_HIGH: begin
              if (!shutdown_reg) begin
                upo_next = 1'b1;
              end
            end
            CTL_EDGE_MODE: begin
              if (fifo_out.code[11]) begin
                mode_rise_next = 1'b1;
              end else if (fifo_out.code[10] == 1'b0) begin
                mode_rise_next = 1'b0;
              end
            end
            default: begin
              upo_next = upo_reg;
            end
          endcase
        end
        if (lock_fall) begin
          shutdown_next = 1'b0;
        end else if (pd_s && lock_s) begin
          shutdown_next = 1'b1;
        end
      end
      ST_CLEAR: begin
        input_code_next = reset_code;
        dac_code_next   = reset_code;
        dac_load_next   = (dac_code_reg != reset_code);
        shutdown_next   = 1'b0;
        upo_next        = 1'b0;
        if (clr_n_s) begin
          state_next      = ST_RUN;
          frame_drop_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
    // A dropped frame flag set in the clearing cycle survives it.
    if (frame_end && !fifo_in_ready) begin
      frame_drop_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_INIT;
      init_cnt_reg   <= 2'h0;
      input_code_reg <= CODE_ZERO;
      dac_code_reg   <= CODE_ZERO;
      dac_load_reg   <= 1'b0;
      upo_reg        <= 1'b0;
      shutdown_reg   <= 1'b0;
      mode_rise_reg  <= 1'b0;
      frame_drop_reg <= 1'b0;
      dout_hold_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      init_cnt_reg   <= init_cnt_next;
      input_code_reg <= input_code_next;
      dac_code_reg   <= dac_code_next;
      dac_load_reg   <= dac_load_next;
      upo_reg        <= upo_next;
      shutdown_reg   <= shutdown_next;
      mode_rise_reg  <= mode_rise_next;
      frame_drop_reg <= frame_drop_next;
      dout_hold_reg  <= dout_hold_next;
    end
  end

  // The link flops see shutdown only after two serial clock edges, so the level is held
  // here; a pin request in mid-frame may catch the line while it moves.
  assign serial_dout       = shutdown_reg ? dout_hold_reg : dout_link;
  assign input_code        = input_code_reg;
  assign dac_code          = dac_code_reg;
  assign dac_load          = dac_load_reg;
  assign user_logic_output = upo_reg;
  assign shutdown          = shutdown_reg;
  assign mode_rise         = mode_rise_reg;
  assign frame_drop        = frame_drop_reg;

endmodule // dsr_top

/* File: dsr_top_asserts.sv */
`timescale 1ns/10ps
module dsr_top_asserts
  import dsr_pkg::*;
(
  input logic        clk_sys,
  input logic        rst_n,
  input logic        serial_clk,
  input logic        chip_select_n,
  input logic        serial_din,
  input logic        serial_dout,
  input logic        clear_input_n,
  input logic        reset_value_select,
  input logic        shutdown_pin,
  input logic        shutdown_lockout,
  input logic        dac_ready,
  input logic [11:0] input_code,
  input logic [11:0] dac_code,
  input logic        dac_load,
  input logic        user_logic_output,
  input logic        shutdown,
  input logic        mode_rise,
  input logic        frame_drop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [11:0] rv;
  assign rv = reset_value_select ? CODE_MID : CODE_ZERO;
  init_load_a:
    assert property ($rose(rst_n) |-> ##[3:6] (input_code == rv && dac_code == rv))
    else $error("Codes not at the reset value after reset.");
  load_pulse_a:
    assert property (dac_load |=> !dac_load) else $error("Load strobe too long.");
  clear_code_a:
    assert property (!clear_input_n [*6] |-> input_code == rv && dac_code == rv)
    else $error("Clear did not load the reset value.");
  clear_state_a:
    assert property (!clear_input_n [*6] |-> !user_logic_output && !shutdown)
    else $error("Clear left logic output or shutdown set.");
  upo_hold_a:
    assert property (shutdown && $past(shutdown) |-> $stable(user_logic_output))
    else $error("Logic output moved in shutdown.");
  dout_hold_a:
    assert property (shutdown && $past(shutdown) |-> $stable(serial_dout))
    else $error("Serial output moved in shutdown.");
  mode_frame_a:
    assert property ($changed(mode_rise) |-> chip_select_n)
    else $error("Edge mode changed inside a frame.");
  upo_cmd_a:
    assert property ($changed(user_logic_output) |-> chip_select_n)
    else $error("Logic output changed inside a frame.");
endmodule // dsr_top_asserts

/* File: dsr_host_model.sv */
`timescale 1ns/10ps
module dsr_host_model (
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      serial_din,
  input  wire logic serial_dout
);
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_din = 1'b0;
  end
  task automatic xfer(input logic [15:0] f, output logic [15:0] lo, output logic [15:0] hi);
    // The offset keeps the link edges away from the system clock edges.
    #3.7 chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_din = f[i];
      #32 lo[i] = serial_dout;
      serial_clk = 1'b1;
      #16 hi[i] = serial_dout;
      #16 serial_clk = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    // line not left at its last value.
    serial_din = ~serial_din;
    #80;
  endtask
endmodule // dsr_host_model

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import dsr_pkg::*;
;
  logic        clk_sys, rst_n, clear_input_n, reset_value_select, shutdown_pin;
  logic        shutdown_lockout, dac_ready, serial_clk, chip_select_n, serial_din;
  logic        serial_dout, dac_load, user_logic_output, shutdown, mode_rise, frame_drop;
  logic [11:0] input_code, dac_code, c, d;
  logic [15:0] prev, lo, hi;
  logic [31:0] seed;
  logic        exp_rise, skip;
  int          error_cnt, check_count;

  dsr_top i_dsr_top (.clk_sys, .rst_n, .serial_clk, .chip_select_n, .serial_din, .serial_dout,
    .clear_input_n, .reset_value_select, .shutdown_pin, .shutdown_lockout, .dac_ready,
    .input_code, .dac_code, .dac_load, .user_logic_output, .shutdown, .mode_rise, .frame_drop);
  dsr_host_model i_dsr_host_model (.serial_clk, .chip_select_n, .serial_din, .serial_dout);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[11:0];
  endfunction

  function automatic logic [15:0] rval();
    return 16'(reset_value_select ? CODE_MID : CODE_ZERO);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Readback of each frame arrives during the following one.
  task automatic frame(input logic [2:0] ctl, input logic [11:0] code);
    logic [15:0] f;
    f = {ctl, code, 1'b0};
    i_dsr_host_model.xfer(f, lo, hi);
    if (!skip) begin
      chk(lo, prev);
      chk(hi, exp_rise ? {prev[14:0], f[15]} : prev);
    end
    prev = f;
    skip = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask

  initial begin
    int k;
    seed = 32'h17;
    prev = 16'h0;
    skip = 1'b0;
    exp_rise = 1'b0;
    error_cnt = 0;
    check_count = 0;
    rst_n = 1'b0;
    clear_input_n = 1'b1;
    shutdown_pin = 1'b0;
    shutdown_lockout = 1'b1;
    dac_ready = 1'b1;
    c = rnd();
    reset_value_select = c[0];
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(16'(input_code), rval());
    chk(16'(dac_code), rval());
    chk(16'(mode_rise), 16'h0);
    chk(16'(user_logic_output), 16'h0);
    $display("Test init done");
    d = reset_value_select ? CODE_MID : CODE_ZERO;
    for (k = 0; k < 4; k++) begin
      c = (k == 0) ? 12'hfff : (k == 1) ? 12'h001 : rnd();
      frame(CTL_LOAD_IN, c);
      chk(16'(input_code), 16'(c));
      chk(16'(dac_code), 16'(d));
      frame(CTL_UPDATE, rnd());
      chk(16'(dac_code), 16'(c));
      d = rnd();
      frame(CTL_LOAD_BOTH, d);
      chk(16'(dac_code), 16'(d));
      chk(16'(input_code), 16'(d));
    end
    $display("Test codes done");
    // Code bits 01 must leave the mode alone, so it sits between the two real choices.
    for (k = 0; k < 3; k++) begin
      c = rnd() & 12'h3ff;
      c[11:10] = (k == 0) ? 2'b10 : (k == 1) ? 2'b01 : 2'b00;
      frame(CTL_EDGE_MODE, c);
      exp_rise = (k != 2);
      chk(16'(mode_rise), 16'(exp_rise));
      skip = 1'b1;
      frame(CTL_NOP, rnd());
      frame(CTL_NOP, rnd());
    end
    $display("Test modes done");
    for (k = 0; k < 3; k++) begin
      frame(k == 1 ? CTL_UPO_LOW : CTL_UPO_HIGH, rnd());
      chk(16'(user_logic_output), 16'(k != 1));
    end
    frame(CTL_SHUTDOWN, rnd());
    chk(16'(shutdown), 16'h1);
    skip = 1'b1;
    c = {12{prev[15]}};
    frame(CTL_UPO_LOW, rnd());
    chk(lo, {16{c[0]}});
    chk(hi, {16{c[0]}});
    chk(16'(user_logic_output), 16'h1);
    reset_value_select = ~reset_value_select;
    repeat (8) @(negedge clk_sys);
    clear_input_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk(16'(dac_code), rval());
    chk(16'(input_code), rval());
    chk(16'(user_logic_output), 16'h0);
    chk(16'(shutdown), 16'h0);
    clear_input_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    $display("Test shutdown done");
    dac_ready = 1'b0;
    skip = 1'b1;
    c = rnd();
    frame(CTL_LOAD_BOTH, c);
    for (k = 0; k < 33; k++) frame(CTL_NOP, rnd());
    chk(16'(frame_drop), 16'h1);
    chk(16'(dac_code), rval());
    dac_ready = 1'b1;
    repeat (40) @(negedge clk_sys);
    chk(16'(dac_code), 16'(c));
    clear_input_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    clear_input_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(16'(frame_drop), 16'h0);
    $display("Test buffer done");
    give_verdict();
  end

  initial begin
    #300000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top

bind dsr_top dsr_top_asserts i_dsr_top_asserts (.clk_sys, .rst_n, .serial_clk, .chip_select_n,
  .serial_din, .serial_dout, .clear_input_n, .reset_value_select, .shutdown_pin,
  .shutdown_lockout, .dac_ready, .input_code, .dac_code, .dac_load, .user_logic_output,
  .shutdown, .mode_rise, .frame_drop);
